// *** hdl/fec_flash_host.sv ***
// flash command host: apb registers in, flash bus cycles out
`timescale 1ns/100ps
module fec_flash_host
    import fec_pkg::*;
#(
    parameter int                WINDOW_CYC  = SECT_WINDOW_US * CLK_MHZ,
    parameter int                HOLDOFF_CYC = HOLDOFF_US * CLK_MHZ,
    parameter int                SUSPEND_CYC = SUSPEND_US * CLK_MHZ,
    parameter logic [ADDR_W-1:0] UNLOCK_A1   = 20'h00001,
    parameter logic [ADDR_W-1:0] UNLOCK_A2   = 20'h00002,
    parameter logic [7:0]        UNLOCK_D1   = 8'h01,
    parameter logic [7:0]        UNLOCK_D2   = 8'h02,
    parameter logic [7:0]        PROG_CODE   = 8'h03,
    parameter logic [7:0]        ID_CODE     = 8'h04,
    parameter logic [7:0]        RESUME_CODE = 8'h05
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // apb slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // flash bus
    output fec_pins_s              pins,
    input  wire logic [DATA_W-1:0] fdataIn
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    typedef enum {S_IDLE, S_WSET, S_WLOW, S_WHIGH, S_RLOW, S_EVAL, S_WAIT} fec_state_e;

    // ****************************************
    // write cycle table
    // ****************************************
    function automatic fec_wr_s seqWord(fec_cmd_e c, logic [2:0] s, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        fec_wr_s w;
        w = '{last: 1'b1, addr: a, data: {8'h00, CODE_RESET}};
        case (c)
            CMD_PROG, CMD_CHIP, CMD_SECT, CMD_IDREAD: begin
                w.last = (c == CMD_PROG) ? (s == 3'd3) : (c == CMD_IDREAD) ? (s == 3'd2) : (s == 3'd5);
                if (s == 3'd0 || s == 3'd3) begin
                    w.addr = UNLOCK_A1;
                    w.data = {8'h00, UNLOCK_D1};
                end else if (s == 3'd1 || s == 3'd4) begin
                    w.addr = UNLOCK_A2;
                    w.data = {8'h00, UNLOCK_D2};
                end else if (s == 3'd2) begin
                    w.addr = UNLOCK_A1;
                    w.data = {8'h00, (c == CMD_PROG) ? PROG_CODE : (c == CMD_IDREAD) ? ID_CODE : CODE_ESETUP};
                end else begin
                    w.data = {8'h00, (c == CMD_CHIP) ? CODE_CHIP : CODE_SECT};
                end
                if (c == CMD_PROG && s == 3'd3) begin
                    w.addr = a;
                    w.data = d;
                end
            end
            CMD_SADD:   w.data = {8'h00, CODE_SECT};
            CMD_SUSP:   w.data = {8'h00, CODE_SUSP};
            CMD_RESUME: w.data = {8'h00, RESUME_CODE};
            default:    w.data = {8'h00, CODE_RESET};
        endcase
        return w;
    endfunction

    // ****************************************
    // flash data synchroniser
    // ****************************************
    logic [DATA_W-1:0] syncA;
    logic [DATA_W-1:0] syncB;
    logic [DATA_W-1:0] syncC;
    logic [DATA_W-1:0] fdata;
    logic [DATA_W-1:0] next_fdata;

    always_comb begin
        next_fdata = (syncB == syncC) ? syncC : fdata;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
            fdata <= '0;
        end else begin
            syncA <= fdataIn;
            syncB <= syncA;
            syncC <= syncB;
            fdata <= next_fdata;
        end
    end

    // ****************************************
    // apb register bus
    // ****************************************
    fec_state_e        state;
    fec_cmd_e          cmd;
    logic [DATA_W-1:0] rdata;
    logic [CNT_W-1:0]  winCnt;
    logic [CNT_W-1:0]  holdCnt;
    logic              done;
    logic              fail;
    logic              refused;
    logic [ADDR_W-1:0] addrReg;
    logic [DATA_W-1:0] wdataReg;
    logic [ADDR_W-1:0] next_addrReg;
    logic [DATA_W-1:0] next_wdataReg;
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic              wr;
    logic              mapped;
    logic              goReq;
    logic              clrReq;
    fec_cmd_e          goCmd;

    always_comb begin
        wr     = psel && penable && pready && pwrite;
        mapped = paddr == OFS_CTRL || paddr == OFS_ADDR || paddr == OFS_WDATA
              || paddr == OFS_STAT || paddr == OFS_RDATA;
        clrReq = wr && paddr == OFS_CTRL;
        goReq  = clrReq && pwdata[CTRL_GO];
        goCmd  = fec_cmd_e'(pwdata[CTRL_CMD+:4]);
        next_addrReg  = (wr && paddr == OFS_ADDR) ? pwdata[ADDR_W-1:0] : addrReg;
        next_wdataReg = (wr && paddr == OFS_WDATA) ? pwdata[DATA_W-1:0] : wdataReg;
        next_pready   = psel && penable && !pready;
        next_pslverr  = next_pready && !mapped;
        next_prdata   = prdata;
        if (next_pready) begin
            case (paddr)
                OFS_CTRL:  next_prdata = {24'h000000, cmd, 4'h0};
                OFS_ADDR:  next_prdata = {12'h000, addrReg};
                OFS_WDATA: next_prdata = {16'h0000, wdataReg};
                OFS_STAT:  next_prdata = {27'h0000000, winCnt > CNT_W'(STROBE_LEAD), refused, fail, done,
                                          state != S_IDLE};
                OFS_RDATA: next_prdata = {16'h0000, rdata};
                default:   next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            addrReg  <= '0;
            wdataReg <= '0;
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            addrReg  <= next_addrReg;
            wdataReg <= next_wdataReg;
            prdata   <= next_prdata;
            pready   <= next_pready;
            pslverr  <= next_pslverr;
        end
    end

    chk_bus_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    // ****************************************
    // command sequencer
    // ****************************************
    logic [2:0]       step;
    logic [7:0]       tmr;
    logic [CNT_W-1:0] waitCnt;
    logic             prevTog;
    logic             prevTo;
    logic             havePrev;
    fec_wr_s          w;
    fec_state_e       next_state;
    fec_cmd_e         next_cmd;
    logic [2:0]       next_step;
    logic [7:0]       next_tmr;
    logic [CNT_W-1:0] next_waitCnt;
    logic [CNT_W-1:0] next_winCnt;
    logic [CNT_W-1:0] next_holdCnt;
    fec_pins_s        next_pins;
    logic [DATA_W-1:0] next_rdata;
    logic             next_prevTog;
    logic             next_prevTo;
    logic             next_havePrev;
    logic             next_done;
    logic             next_fail;
    logic             next_refused;

    always_comb begin
        w             = seqWord(cmd, step, addrReg, wdataReg);
        next_state    = state;
        next_cmd      = cmd;
        next_step     = step;
        next_tmr      = (tmr != 8'h00) ? tmr - 8'h01 : tmr;
        next_waitCnt  = (waitCnt != '0) ? waitCnt - CNT_W'(1) : waitCnt;
        next_winCnt   = (winCnt != '0) ? winCnt - CNT_W'(1) : winCnt;
        next_holdCnt  = (holdCnt != '0) ? holdCnt - CNT_W'(1) : holdCnt;
        next_pins     = pins;
        next_rdata    = rdata;
        next_prevTog  = prevTog;
        next_prevTo   = prevTo;
        next_havePrev = havePrev;
        next_done     = clrReq ? 1'b0 : done;
        next_fail     = clrReq ? 1'b0 : fail;
        next_refused  = clrReq ? 1'b0 : refused;
        case (state)
            S_IDLE: begin
                next_pins = PINS_IDLE;
                if (goReq) begin
                    if ((goCmd == CMD_SADD && winCnt <= CNT_W'(STROBE_LEAD))
                        || (goCmd == CMD_SUSP && holdCnt != '0)) begin
                        next_refused = 1'b1;
                    end else begin
                        next_cmd      = goCmd;
                        next_step     = 3'd0;
                        next_havePrev = 1'b0;
                        next_tmr      = 8'(READ_CYC);
                        next_state    = (goCmd == CMD_READ || goCmd == CMD_POLL) ? S_RLOW : S_WSET;
                    end
                end
            end
            S_WSET: begin
                next_pins  = '{addr: w.addr, dout: w.data, doe: 1'b1, ceN: 1'b0, weN: 1'b1, oeN: 1'b1};
                next_tmr   = 8'(WE_LOW_CYC);
                next_state = S_WLOW;
            end
            S_WLOW: begin
                next_pins.weN = 1'b0;
                if (tmr == 8'h00) begin
                    next_pins.weN = 1'b1;
                    next_pins.ceN = 1'b1;
                    next_tmr      = 8'(WE_HIGH_CYC);
                    next_state    = S_WHIGH;
                    if (w.last && (cmd == CMD_SECT || cmd == CMD_SADD)) begin
                        next_winCnt = CNT_W'(WINDOW_CYC);
                    end
                    if (cmd == CMD_SUSP) begin
                        next_winCnt = '0;
                    end
                end
            end
            S_WHIGH: begin
                next_pins.doe = 1'b0;
                if (tmr == 8'h00) begin
                    next_state = S_IDLE;
                    next_tmr   = 8'(READ_CYC);
                    if (!w.last) begin
                        next_step  = step + 3'd1;
                        next_state = S_WSET;
                    end else if (cmd == CMD_PROG || cmd == CMD_CHIP || cmd == CMD_IDREAD) begin
                        next_state = S_RLOW;
                    end else if (cmd == CMD_SUSP) begin
                        next_waitCnt = CNT_W'(SUSPEND_CYC);
                        next_state   = S_WAIT;
                    end else begin
                        next_done = 1'b1;
                        if (cmd == CMD_RESUME) begin
                            next_holdCnt = CNT_W'(HOLDOFF_CYC);
                        end
                    end
                end
            end
            S_RLOW: begin
                next_pins = '{addr: addrReg, dout: '0, doe: 1'b0, ceN: 1'b0, weN: 1'b1, oeN: 1'b0};
                if (tmr == 8'h00) begin
                    next_rdata    = fdata;
                    next_pins.ceN = 1'b1;
                    next_pins.oeN = 1'b1;
                    next_state    = S_EVAL;
                end
            end
            S_EVAL: begin
                next_prevTog  = rdata[TOGGLE_BIT];
                next_prevTo   = rdata[TIMEOUT_BIT];
                next_havePrev = 1'b1;
                next_tmr      = 8'(READ_CYC);
                next_state    = S_RLOW;
                if (cmd == CMD_READ || cmd == CMD_IDREAD) begin
                    next_done  = 1'b1;
                    next_state = S_IDLE;
                end else if (havePrev && rdata[TOGGLE_BIT] == prevTog) begin
                    next_done  = 1'b1;
                    next_state = S_IDLE;
                end else if (havePrev && prevTo) begin
                    next_fail  = 1'b1;
                    next_cmd   = CMD_RESET;
                    next_step  = 3'd0;
                    next_state = S_WSET;
                end
            end
            S_WAIT: begin
                if (waitCnt == '0) begin
                    next_done  = 1'b1;
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
        if (goReq && state != S_IDLE) begin
            next_refused = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state    <= S_IDLE;
            cmd      <= CMD_READ;
            step     <= 3'd0;
            tmr      <= 8'h00;
            waitCnt  <= '0;
            winCnt   <= '0;
            holdCnt  <= '0;
            pins     <= PINS_IDLE;
            rdata    <= '0;
            prevTog  <= 1'b0;
            prevTo   <= 1'b0;
            havePrev <= 1'b0;
            done     <= 1'b0;
            fail     <= 1'b0;
            refused  <= 1'b0;
        end else begin
            state    <= next_state;
            cmd      <= next_cmd;
            step     <= next_step;
            tmr      <= next_tmr;
            waitCnt  <= next_waitCnt;
            winCnt   <= next_winCnt;
            holdCnt  <= next_holdCnt;
            pins     <= next_pins;
            rdata    <= next_rdata;
            prevTog  <= next_prevTog;
            prevTo   <= next_prevTo;
            havePrev <= next_havePrev;
            done     <= next_done;
            fail     <= next_fail;
            refused  <= next_refused;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_erase_setup: assert property (state == S_WLOW && step == 3'd2 && (cmd == CMD_CHIP || cmd == CMD_SECT)
        |-> pins.dout == {8'h00, CODE_ESETUP}) else $error("erase set-up code wrong");
    chk_erase_final: assert property (state == S_WHIGH && step == 3'd5 && tmr == 8'h00
        |=> state == S_IDLE || state == S_RLOW) else $error("erase longer than six writes");
    chk_prog_length: assert property (cmd == CMD_PROG && state == S_WSET |-> step <= 3'd3)
        else $error("program longer than four writes");
    chk_reset_code: assert property (cmd == CMD_RESET && state == S_WLOW |-> pins.dout == {8'h00, CODE_RESET})
        else $error("reset code wrong");
    chk_poll_stop: assert property (state == S_EVAL && havePrev && cmd == CMD_POLL && rdata[TOGGLE_BIT] == prevTog
        |=> state == S_IDLE && done) else $error("poll did not stop");
    chk_fail_reset: assert property (state == S_EVAL && havePrev && prevTo && cmd == CMD_POLL
        && rdata[TOGGLE_BIT] != prevTog |=> state == S_WSET && cmd == CMD_RESET ##[1:40] state == S_IDLE)
        else $error("no reset after timeout");
    chk_window_late: assert property (state == S_IDLE && goReq && goCmd == CMD_SADD && winCnt <= CNT_W'(STROBE_LEAD)
        |=> refused && state == S_IDLE) else $error("late sector load issued");
    chk_holdoff: assert property ($fell(state == S_WHIGH) && cmd == CMD_RESUME && state == S_IDLE
        |-> holdCnt == CNT_W'(HOLDOFF_CYC)) else $error("resume hold-off not loaded");
    chk_window_load: assert property (state == S_WLOW && tmr == 8'h00 && cmd == CMD_SECT && step == 3'd5
        |=> winCnt == CNT_W'(WINDOW_CYC) && pins.weN) else $error("sector window not opened");
endmodule

// *** hdl/fec_pkg.sv ***
// package: constants, commands and carriers of the flash command host
package fec_pkg;
    localparam int ADDR_W  = 20;
    localparam int DATA_W  = 16;
    localparam int CNT_W   = 24;
    localparam int CLK_MHZ = 250;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_ADDR  = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_STAT  = 8'h0C;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    localparam int CTRL_GO    = 0;
    localparam int CTRL_CMD   = 4;
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_FAIL    = 2;
    localparam int ST_REFUSED = 3;
    localparam int ST_WINDOW  = 4;
    // ****************************************
    // flash status bits and command codes
    // ****************************************
    localparam int TOGGLE_BIT  = 6;
    localparam int TIMEOUT_BIT = 5;
    localparam logic [7:0] CODE_ESETUP = 8'h80;
    localparam logic [7:0] CODE_CHIP   = 8'h10;
    localparam logic [7:0] CODE_SECT   = 8'h30;
    localparam logic [7:0] CODE_SUSP   = 8'hB0;
    localparam logic [7:0] CODE_RESET  = 8'hF0;
    // ****************************************
    // timing
    // ****************************************
    localparam int WE_LOW_NS      = 35;
    localparam int WE_HIGH_NS     = 30;
    localparam int READ_NS        = 70;
    localparam int SYNC_CYC       = 3;
    localparam int WE_LOW_CYC     = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int WE_HIGH_CYC    = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYC       = (READ_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
    localparam int SECT_WINDOW_US = 50;
    localparam int SUSPEND_US     = 20;
    localparam int HOLDOFF_US     = 10000;
    localparam int STROBE_LEAD    = 16;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        CMD_READ, CMD_PROG, CMD_CHIP, CMD_SECT, CMD_SADD,
        CMD_SUSP, CMD_RESUME, CMD_RESET, CMD_IDREAD, CMD_POLL
    } fec_cmd_e;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic              doe;
        logic              ceN;
        logic              weN;
        logic              oeN;
    } fec_pins_s;
    typedef struct packed {
        logic              last;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fec_wr_s;
    localparam fec_pins_s PINS_IDLE = '{addr: '0, dout: '0, doe: 1'b0, ceN: 1'b1, weN: 1'b1, oeN: 1'b1};
endpackage

// *** tb/fec_flash_host_tb_top.sv ***
// self-checking bench of the flash command host with a flash model
`timescale 1ns/100ps
`define CHK(n, x, g) begin total_checks++; if ((g) !== (x)) begin err_total++; $display("FAIL %s exp %0h got %0h", n, x, g); end end
module fec_flash_host_tb_top
    import fec_pkg::*;
;
    logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, failMode = 0, pready, pslverr, e;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, q, seed = 32'h9253032D;
    logic [19:0] ad;
    logic [15:0] fOut, fdataIn;
    fec_pins_s   pins;
    int          err_total = 0, total_checks = 0;

    fec_flash_host #(.WINDOW_CYC(200), .HOLDOFF_CYC(300), .SUSPEND_CYC(50)) uut (
        .clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .fdataIn(fdataIn));
    fec_flash_model mdl (.pins(pins), .failMode(failMode), .fOut(fOut));
    // wire level: the host wins while its enable is high
    assign fdataIn = pins.doe ? pins.dout : fOut;
    initial forever #2 clk = ~clk;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] exp_rd(input logic id, input logic [19:0] a);
        if (!id) return {16'h0, a[15:0] ^ 16'hA5C3};
        return a[1] ? {31'h0, a[12]} : (a[0] ? 32'h2233 : 32'h0011);
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) err_total++;
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // one command: address, data, go, then poll until idle
    task automatic op(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d);
        int n;
        apb(1, OFS_ADDR, {12'h0, a});
        apb(1, OFS_WDATA, {16'h0, d});
        apb(1, OFS_CTRL, {24'h0, c, 4'h1});
        n = 0;
        do begin
            apb(0, OFS_STAT, 0);
            n++;
        end while (q[ST_BUSY] !== 1'b0 && n < 5000);
        if (q[ST_BUSY] !== 1'b0) err_total++;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        apb(0, OFS_STAT, 0);
        `CHK("stat", 32'h0, q)
        apb(0, 8'h14, 0);
        `CHK("slverr", 1'b1, e)
        `CHK("unmapped", 32'h0, q)
        $display("register test ended");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            op(CMD_READ, seed[19:0], 16'h0);
            apb(0, OFS_RDATA, 0);
            `CHK("array", exp_rd(0, seed[19:0]), q)
            op(CMD_IDREAD, {seed[19:2], i[1:0]}, 16'h0);
            apb(0, OFS_RDATA, 0);
            `CHK("ident", exp_rd(1, {seed[19:2], i[1:0]}), q)
            op(CMD_RESET, seed[31:12], 16'h0);
            `CHK("id exit", 1'b0, mdl.idm)
        end
        $display("read test ended");
        seed = lfsr(seed);
        op(CMD_PROG, seed[19:0], seed[31:16]);
        `CHK("prog stat", 32'h2, q)
        `CHK("prog addr", seed[19:0], mdl.pa)
        `CHK("prog data", seed[31:16], mdl.pd)
        apb(0, OFS_CTRL, 0);
        `CHK("ctrl", 32'h10, q)
        op(CMD_CHIP, 20'h0, 16'h0);
        `CHK("chip stat", 32'h2, q)
        `CHK("chip code", 8'h10, mdl.lastErase)
        failMode <= 1'b1;
        op(CMD_CHIP, 20'h0, 16'h0);
        `CHK("chip fail", 1'b1, q[ST_FAIL])
        `CHK("fail reset", 0, mdl.busy)
        failMode <= 1'b0;
        $display("program erase test ended");
        ad = seed[31:12];
        op(CMD_SECT, ad, 16'h0);
        `CHK("window", 1'b1, q[ST_WINDOW])
        op(CMD_SADD, ad ^ 20'h10000, 16'h0);
        `CHK("sectors", 2, mdl.nSect)
        op(CMD_SUSP, ad, 16'h0);
        `CHK("suspended", 1'b1, mdl.susp)
        `CHK("window shut", 1'b0, q[ST_WINDOW])
        op(CMD_RESUME, ad, 16'h0);
        `CHK("resumed", 1'b0, mdl.susp)
        op(CMD_SUSP, ad, 16'h0);
        `CHK("refused", 1'b1, q[ST_REFUSED])
        op(CMD_SADD, ad, 16'h0);
        `CHK("late load", 1'b1, q[ST_REFUSED])
        $display("suspend test ended");
        final_report();
    end
endmodule

// *** tb/fec_flash_model.sv ***
// behavioural flash device answering the host's bus cycles
`timescale 1ns/100ps
module fec_flash_model
    import fec_pkg::*;
#(
    parameter int          BR    = 4,
    parameter logic [15:0] MAKER = 16'h0011,
    parameter logic [15:0] PART  = 16'h2233
) (
    // flash pins and fail mode control
    input  fec_pins_s   pins,
    input  logic        failMode,
    output logic [15:0] fOut
);
    // maker and part values above are arbitrary
    int          busy = 0, step = 0, nSect = 0;
    logic        idm = 0, win = 0, susp = 0, tog = 0, to = 0, k1, k2;
    logic [7:0]  d, lastErase = '0, sa = '0;
    logic [19:0] a, pa = '0;
    logic [15:0] pd = '1, last = '0, rd;
    // status while busy, codes in identifier mode, else array data
    // suspended sector reads status, others read array
    always_comb begin
        if (busy > 0) rd = {9'h0, tog, to, 5'h0};
        else if (susp && pins.addr[19:12] == sa) rd = {9'h0, tog, to, 5'h0};
        else if (idm) rd = pins.addr[1] ? {15'h0, pins.addr[12]} : (pins.addr[0] ? PART : MAKER);
        else rd = pins.addr[15:0] ^ 16'hA5C3;
    end
    // released bus shows the inverse of the last value
    assign fOut = (!pins.ceN && !pins.oeN) ? rd : ~last;
    // self-timed run ends after a few status reads unless timed out, then array read
    always @(posedge pins.oeN) begin
        last = rd;
        tog = ~tog;
        if (busy > 0 && !to) busy--;
    end
    // commands act at the write strobe rise
    // address at the fall, data at the rise
    always @(negedge pins.weN) begin
        a = pins.addr;
    end
    always @(posedge pins.weN) begin
        d = pins.dout[7:0];
        k1 = a == 20'h1 && d == 8'h01;
        k2 = a == 20'h2 && d == 8'h02;
        if (d == 8'hF0 && (busy == 0 || to)) begin
            {idm, win, to} = 3'b000;
            busy = 0;
            step = 0;
        end else if (busy > 0) begin
            step = 0;
        end else if (win) begin
            win = d == 8'h30;
            nSect += int'(win);
            susp = d == 8'hB0;
        end else if (susp && d == 8'h05) begin
            susp = 0;
            busy = BR;
        end else begin
            case (step)
                0, 3: step = k1 ? step + 1 : 0;
                1, 4: step = k2 ? step + 1 : 0;
                2: begin
                    idm = a == 20'h1 && d == 8'h04;
                    step = a != 20'h1 ? 0 : d == 8'h80 ? 3 : d == 8'h03 ? 6 : 0;
                end
                5: begin
                    lastErase = d;
                    sa = a[19:12];
                    win = d == 8'h30;
                    nSect = int'(win);
                    to = failMode && d == 8'h10;
                    busy = d == 8'h10 ? BR : 0;
                    step = 0;
                end
                6: begin
                    pa = a;
                    pd = pd & pins.dout;
                    busy = BR;
                    step = 0;
                end
                default: step = 0;
            endcase
        end
    end
endmodule
